// ### design/atrc_control.sv
`timescale 1ns/1ns
`default_nettype none
module atrc_control #(
  parameter int START_LEN = atrc_pkg::START_CYCLES,
  parameter int END_LEN = atrc_pkg::END_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Software control
  input wire atrc_pkg::atrc_ctrl_t ctrl,
  input wire atrc_pkg::atrc_ext_t ext_cfg,
  input wire logic timer_trigger,
  // Pins
  input wire logic ext_conversion_trigger_pin,
  // Analog front end
  input wire logic [atrc_pkg::RESULT_W-1:0] converter_sample,
  output logic analog_power_on,
  output logic [3:0] analog_channel,
  output logic onchip_reference_input,
  output logic precharge_active,
  output logic discharge_active,
  output logic sampling,
  // Status
  output logic conversion_start_bit,
  output logic irq_request_flag,
  output logic conv_irq_pulse,
  output logic busy,
  output logic [atrc_pkg::RESULT_COUNT*atrc_pkg::RESULT_W-1:0] results
);

  localparam int CNT_MAX = (1 << atrc_pkg::CNT_W) - 1;

  // Counter must hold start, end and execution lengths
  if (START_LEN < 1 || START_LEN > CNT_MAX ||
      END_LEN < 1 || END_LEN > CNT_MAX) begin : g_len_chk
    $error("atrc_control: phase length out of range");
  end
  if (atrc_pkg::EXEC_CYCLES_ASSIST + atrc_pkg::EXEC_TAIL_CYCLES > CNT_MAX) begin : g_exec_chk
    $error("atrc_control: execution length out of range");
  end

  localparam logic [5:0] START_L = 6'(START_LEN);
  localparam logic [5:0] END_L = 6'(END_LEN);
  localparam logic [5:0] EXEC_PLAIN = 6'(atrc_pkg::EXEC_CYCLES_PLAIN + atrc_pkg::EXEC_TAIL_CYCLES);
  localparam logic [5:0] EXEC_ASSIST = 6'(atrc_pkg::EXEC_CYCLES_ASSIST + atrc_pkg::EXEC_TAIL_CYCLES);
  localparam logic [5:0] ASSIST_L = 6'(atrc_pkg::ASSIST_CYCLES);
  localparam logic [5:0] BETWEEN_L = 6'(atrc_pkg::BETWEEN_CYCLES);

  atrc_pkg::atrc_state_t state_reg;
  logic [5:0] cnt_reg;
  logic start_reg;
  logic pin_reg;
  logic [atrc_pkg::RESULT_W-1:0] result_mem [atrc_pkg::RESULT_COUNT];
  logic [atrc_pkg::RESULT_IDX_W-1:0] slot;
  logic pin_fall;
  logic pin_rise;
  logic edge_hit;
  logic trig_hit;
  logic ref_sel;
  logic mode_ok;
  logic done;
  logic repeat0;
  logic [atrc_pkg::RESULT_W-1:0] sample_res;
  logic [5:0] exec_len;
  logic abort_req;

  // Input index to result register
  function automatic logic [2:0] atrc_slot(input logic [3:0] inp, input logic ref_on);
    if (ref_on) begin
      atrc_slot = atrc_pkg::RESULT_REF_IDX;
    end else if (inp[3]) begin
      atrc_slot = {1'b0, inp[1:0]};
    end else begin
      atrc_slot = inp[2:0];
    end
  endfunction

  assign repeat0 = (ctrl.mode == atrc_pkg::MODE_REPEAT0);
  assign mode_ok = (ctrl.mode == atrc_pkg::MODE_ONE_SHOT) || repeat0;
  assign ref_sel = ctrl.extended_input_select && ctrl.ref_input_connect_bit && mode_ok;
  // selected input from channel and group
  assign analog_channel = {ctrl.channel_group_sel[0], ctrl.channel_select};
  // route by input, reference to 0
  assign slot = atrc_slot(analog_channel, ref_sel);
  assign onchip_reference_input = ref_sel;
  assign analog_power_on = ctrl.standby_on;
  assign busy = (state_reg != atrc_pkg::ATRC_IDLE) && (state_reg != atrc_pkg::ATRC_ARMED);
  assign exec_len = ctrl.open_circuit_assist_enable ? EXEC_ASSIST : EXEC_PLAIN;
  // software clear of the start bit
  assign abort_req = ctrl.start_write && !ctrl.start_value;

  assign pin_fall = pin_reg && !ext_conversion_trigger_pin;
  assign pin_rise = !pin_reg && ext_conversion_trigger_pin;

  // edge per polarity and both-edge select
  always_comb begin
    edge_hit = 1'b0;
    if (ext_cfg.ext_irq_input_enable) begin
      if (ext_cfg.ext_irq_both_edge_sel) begin
        edge_hit = pin_fall || pin_rise;
      end else begin
        edge_hit = ext_cfg.edge_polarity_bit ? pin_rise : pin_fall;
      end
    end
  end

  always_comb begin
    case (ctrl.trigger_source)
      atrc_pkg::TRIG_EXTERNAL: trig_hit = pin_fall;
      atrc_pkg::TRIG_TIMER: trig_hit = timer_trigger;
      default: trig_hit = 1'b1;
    endcase
  end

  assign sample_res = ctrl.ten_bit ? converter_sample :
    {2'h0, converter_sample[atrc_pkg::RESULT_W-1 -: 8]};

  assign done = (state_reg == atrc_pkg::ATRC_CONVERT) && (cnt_reg == 6'h01);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= ext_conversion_trigger_pin;
    end
  end

  // Start bit, software clear aborts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else if (ctrl.start_write) begin
      start_reg <= ctrl.start_value;
    end else if (state_reg == atrc_pkg::ATRC_FINISH && cnt_reg == 6'h01 &&
                 !repeat0 && ctrl.trigger_source == atrc_pkg::TRIG_SOFTWARE) begin
      start_reg <= 1'b0;
    end
  end

  // start bit reads 0 in idle and startup, and while armed for software trigger
  assign conversion_start_bit = start_reg && (state_reg != atrc_pkg::ATRC_IDLE) &&
    (state_reg != atrc_pkg::ATRC_STARTUP) &&
    !(state_reg == atrc_pkg::ATRC_ARMED && ctrl.trigger_source == atrc_pkg::TRIG_SOFTWARE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= atrc_pkg::ATRC_IDLE;
      cnt_reg <= 6'h00;
    end else if (!start_reg || abort_req) begin
      state_reg <= atrc_pkg::ATRC_IDLE;
      cnt_reg <= 6'h00;
    end else begin
      case (state_reg)
        atrc_pkg::ATRC_IDLE: begin
          state_reg <= atrc_pkg::ATRC_ARMED;
        end
        atrc_pkg::ATRC_ARMED: begin
          if (trig_hit && ctrl.standby_on) begin
            state_reg <= atrc_pkg::ATRC_STARTUP;
            cnt_reg <= START_L;
          end
        end
        atrc_pkg::ATRC_STARTUP: begin
          if (cnt_reg == 6'h01) begin
            state_reg <= atrc_pkg::ATRC_CONVERT;
            cnt_reg <= exec_len;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        atrc_pkg::ATRC_CONVERT: begin
          if (done) begin
            state_reg <= repeat0 ? atrc_pkg::ATRC_BETWEEN : atrc_pkg::ATRC_FINISH;
            cnt_reg <= repeat0 ? BETWEEN_L : END_L;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        atrc_pkg::ATRC_BETWEEN: begin
          if (cnt_reg == 6'h01) begin
            state_reg <= atrc_pkg::ATRC_CONVERT;
            cnt_reg <= exec_len;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        atrc_pkg::ATRC_FINISH: begin
          if (cnt_reg == 6'h01) begin
            state_reg <= atrc_pkg::ATRC_ARMED;
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        default: begin
          state_reg <= atrc_pkg::ATRC_IDLE;
          cnt_reg <= 6'h00;
        end
      endcase
    end
  end

  // assist phase at start of execution
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      precharge_active <= 1'b0;
      discharge_active <= 1'b0;
      sampling <= 1'b0;
    end else begin
      precharge_active <= 1'b0;
      discharge_active <= 1'b0;
      sampling <= 1'b0;
      if (state_reg == atrc_pkg::ATRC_CONVERT && !done) begin
        if (ctrl.open_circuit_assist_enable && cnt_reg > exec_len - ASSIST_L) begin
          precharge_active <= ctrl.open_circuit_assist_method;
          discharge_active <= !ctrl.open_circuit_assist_method;
        end else begin
          sampling <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (done && start_reg && !abort_req) begin
      result_mem[slot] <= sample_res;
    end
  end

  always_comb begin
    for (int i = 0; i < atrc_pkg::RESULT_COUNT; i++) begin
      results[i*atrc_pkg::RESULT_W +: atrc_pkg::RESULT_W] = result_mem[i];
    end
  end

  // one-shot completion request, none in repeat 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_irq_pulse <= 1'b0;
    end else begin
      conv_irq_pulse <= done && !repeat0 && !abort_req;
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request_flag <= 1'b0;
    end else if (edge_hit) begin
      irq_request_flag <= 1'b1;
    end else if (ext_cfg.irq_flag_clear) begin
      irq_request_flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### design/atrc_pkg.sv
package atrc_pkg;
  // Trigger source codes
  localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
  localparam logic [1:0] TRIG_TIMER = 2'h2;
  localparam logic [1:0] TRIG_EXTERNAL = 2'h3;
  // Operating mode codes
  localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
  localparam logic [2:0] MODE_REPEAT0 = 3'h1;
  // Phase lengths in converter clock cycles
  localparam int START_CYCLES = 2;
  localparam int EXEC_CYCLES_PLAIN = 40;
  localparam int EXEC_CYCLES_ASSIST = 42;
  localparam int EXEC_TAIL_CYCLES = 1;
  localparam int BETWEEN_CYCLES = 1;
  localparam int END_CYCLES = 2;
  localparam int ASSIST_CYCLES = EXEC_CYCLES_ASSIST - EXEC_CYCLES_PLAIN;
  localparam int CNT_W = 6;
  // Result layout
  localparam int RESULT_W = 10;
  localparam int RESULT_COUNT = 8;
  localparam int RESULT_IDX_W = 3;
  localparam logic [RESULT_IDX_W-1:0] RESULT_REF_IDX = 3'h0;

  typedef enum logic [2:0] {
    ATRC_IDLE = 3'b000,
    ATRC_ARMED = 3'b001,
    ATRC_STARTUP = 3'b010,
    ATRC_CONVERT = 3'b011,
    ATRC_BETWEEN = 3'b100,
    ATRC_FINISH = 3'b101
  } atrc_state_t;

  // Software control bits
  typedef struct packed {
    logic start_write;
    logic start_value;
    logic [1:0] trigger_source;
    logic [2:0] mode;
    logic standby_on;
    logic ten_bit;
    logic extended_input_select;
    logic ref_input_connect_bit;
    logic open_circuit_assist_enable;
    logic open_circuit_assist_method;
    logic [2:0] channel_select;
    logic [1:0] channel_group_sel;
  } atrc_ctrl_t;

  // External trigger interrupt setup
  typedef struct packed {
    logic ext_irq_input_enable;
    logic ext_irq_both_edge_sel;
    logic edge_polarity_bit;
    logic irq_flag_clear;
  } atrc_ext_t;
endpackage

// ### tb/atrc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module atrc_chk (
  // Clock, reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire atrc_pkg::atrc_ctrl_t ctrl,
  input wire atrc_pkg::atrc_ext_t ext_cfg,
  input wire logic ext_conversion_trigger_pin,
  // Outputs
  input wire logic analog_power_on,
  input wire logic precharge_active,
  input wire logic discharge_active,
  input wire logic conversion_start_bit,
  input wire logic irq_request_flag,
  input wire logic conv_irq_pulse
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic sw1, go, asst, rep, fe;
  assign sw1 = ctrl.trigger_source == atrc_pkg::TRIG_SOFTWARE &&
    ctrl.mode == atrc_pkg::MODE_ONE_SHOT;
  assign go = sw1 && ctrl.start_write && ctrl.start_value && ctrl.standby_on;
  assign asst = ctrl.open_circuit_assist_enable;
  assign rep = ctrl.mode == atrc_pkg::MODE_REPEAT0;
  assign fe = ext_cfg.ext_irq_input_enable && !ext_cfg.ext_irq_both_edge_sel;
  a_power_follows_standby: assert property (analog_power_on == ctrl.standby_on)
    else $error("power");
  a_start_reads_zero: assert property (go |=> !conversion_start_bit [*3])
    else $error("start bit");
  a_plain_conv_len: assert property (go && !asst |-> ##46 conv_irq_pulse)
    else $error("length");
  a_assist_conv_len: assert property (go && asst |-> ##48 conv_irq_pulse)
    else $error("assist length");
  a_done_clears_start: assert property (conv_irq_pulse && sw1 |-> ##2 !conversion_start_bit)
    else $error("start not cleared");
  a_irq_one_cycle: assert property (conv_irq_pulse |=> !conv_irq_pulse)
    else $error("pulse width");
  a_repeat_no_irq: assert property (rep && $past(rep) |-> !conv_irq_pulse)
    else $error("repeat irq");
  a_abort_no_irq: assert property (ctrl.start_write && !ctrl.start_value |=> !conv_irq_pulse [*4])
    else $error("abort irq");
  a_ext_sets_flag: assert property (fe && !ext_cfg.edge_polarity_bit &&
    $fell(ext_conversion_trigger_pin) |-> ##[1:2] irq_request_flag)
    else $error("ext flag");
  a_assist_method: assert property (precharge_active || discharge_active |-> asst &&
    precharge_active == ctrl.open_circuit_assist_method && !(precharge_active && discharge_active))
    else $error("assist");
  c_irq: cover property (conv_irq_pulse);
  c_pre: cover property (precharge_active);
  c_dis: cover property (discharge_active);
endmodule
bind atrc_control atrc_chk u_chk (.mclk, .rst_n, .ctrl, .ext_cfg, .ext_conversion_trigger_pin,
  .analog_power_on, .precharge_active, .discharge_active, .conversion_start_bit,
  .irq_request_flag, .conv_irq_pulse);
`default_nettype wire

// ### tb/atrc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module atrc_analog_model (
  // Bench side
  input wire logic [9:0] base,
  input wire logic fire,
  // Converter side
  input wire logic analog_power_on,
  input wire logic [3:0] analog_channel,
  input wire logic onchip_reference_input,
  output logic [9:0] converter_sample,
  output logic ext_conversion_trigger_pin
);
  logic [9:0] v;
  assign v = base ^ {onchip_reference_input ? 5'h10 : {1'b0, analog_channel}, 5'h15};
  assign converter_sample = analog_power_on ? v : ~v;
  assign ext_conversion_trigger_pin = !fire;
endmodule
`default_nettype wire

// ### tb/adc_trigger_result_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_result_control_tb;
  logic mclk, rst_n, tmr, fire, pin, pwr, rf_in, csb, irqf, pulse, busy, pre, dis, samp;
  atrc_pkg::atrc_ctrl_t ctrl;
  atrc_pkg::atrc_ext_t ext_cfg;
  logic [9:0] base, smp;
  logic [3:0] chan;
  logic [79:0] res;
  logic [9:0] exp_res [8];
  logic [7:0] known;
  logic [31:0] rng;
  int num_errors, n_tests, npulse, nsamp, nasst;
  atrc_control DUT (.mclk, .rst_n, .ctrl, .ext_cfg, .timer_trigger(tmr),
    .ext_conversion_trigger_pin(pin), .converter_sample(smp), .analog_power_on(pwr),
    .analog_channel(chan), .onchip_reference_input(rf_in), .precharge_active(pre),
    .discharge_active(dis), .sampling(samp), .conversion_start_bit(csb), .irq_request_flag(irqf),
    .conv_irq_pulse(pulse), .busy, .results(res));
  atrc_analog_model u_model (.base, .fire, .analog_power_on(pwr), .analog_channel(chan),
    .onchip_reference_input(rf_in), .converter_sample(smp), .ext_conversion_trigger_pin(pin));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (pulse === 1'b1) npulse <= npulse + 1;
  always @(posedge mclk) if (samp === 1'b1) nsamp <= nsamp + 1;
  always @(posedge mclk) if (pre === 1'b1 || dis === 1'b1) nasst <= nasst + 1;
  function automatic logic [9:0] asst_len(input logic en);
    return en ? 10'(atrc_pkg::ASSIST_CYCLES) : 10'h000;
  endfunction
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk_val(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %b seen %b", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic start(input logic v);
    @(posedge mclk);
    ctrl.start_write <= 1'b1;
    ctrl.start_value <= v;
    @(posedge mclk);
    ctrl.start_write <= 1'b0;
  endtask
  task automatic setup(input logic [1:0] trg, input logic [2:0] md);
    logic [31:0] r;
    logic rf;
    r = xs();
    rf = r[2:1] == 2'h0;
    @(posedge mclk);
    ctrl.trigger_source <= trg;
    ctrl.mode <= md;
    ctrl.ten_bit <= r[0];
    ctrl.extended_input_select <= rf;
    ctrl.ref_input_connect_bit <= rf;
    ctrl.open_circuit_assist_enable <= r[3] && !rf;
    ctrl.open_circuit_assist_method <= r[4];
    ctrl.channel_group_sel <= {1'b0, r[5] && !rf};
    ctrl.channel_select <= rf ? 3'h0 : {r[8] && !r[5], r[7:6]};
    start(1'b1);
  endtask
  task automatic note();
    logic [9:0] s;
    s = base ^ {ctrl.extended_input_select ? 5'h10 :
      {1'b0, ctrl.channel_group_sel[0], ctrl.channel_select}, 5'h15};
    exp_res[ctrl.channel_select] = ctrl.ten_bit ? s : {2'h0, s[9:2]};
    known[ctrl.channel_select] = 1'b1;
    for (int i = 0; i < 8; i++)
      if (known[i]) chk_val("result", exp_res[i], res[i*10+:10]);
  endtask
  task automatic wait_done();
    int n0, s0, a0;
    n0 = npulse;
    s0 = nsamp;
    a0 = nasst;
    for (int i = 0; i < 300 && npulse == n0; i++) @(posedge mclk);
    chk_bit("irq pulse", 1'b1, npulse != n0);
    chk_val("sample cycles", 10'(atrc_pkg::EXEC_CYCLES_PLAIN), 10'(nsamp - s0));
    chk_val("assist cycles", asst_len(ctrl.open_circuit_assist_enable), 10'(nasst - a0));
    repeat (3) @(posedge mclk);
    note();
  endtask
  initial begin
    int n0;
    ctrl = '0;
    ext_cfg = 4'h8;
    {tmr, fire, npulse, num_errors, n_tests, known} = '0;
    base = 10'h2A5;
    rng = 32'h9;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    ctrl.standby_on <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_bit("power", 1'b1, pwr);
    repeat (12) begin
      setup(atrc_pkg::TRIG_SOFTWARE, atrc_pkg::MODE_ONE_SHOT);
      wait_done();
      chk_bit("start bit", 1'b0, csb);
    end
    setup(atrc_pkg::TRIG_EXTERNAL, atrc_pkg::MODE_ONE_SHOT);
    repeat (5) @(posedge mclk);
    fire <= 1'b1;
    wait_done();
    chk_bit("irq flag", 1'b1, irqf);
    fire <= 1'b0;
    ext_cfg.irq_flag_clear <= 1'b1;
    @(posedge mclk);
    ext_cfg.irq_flag_clear <= 1'b0;
    @(posedge mclk);
    chk_bit("irq flag", 1'b0, irqf);
    for (int k = 0; k < 2; k++) begin
      setup(atrc_pkg::TRIG_TIMER, atrc_pkg::MODE_ONE_SHOT);
      repeat (4) @(posedge mclk);
      tmr <= 1'b1;
      @(posedge mclk);
      tmr <= 1'b0;
      if (k == 0) wait_done();
    end
    n0 = npulse;
    repeat (20) @(posedge mclk);
    start(1'b0);
    repeat (80) @(posedge mclk);
    chk_bit("abort irq", 1'b0, npulse != n0);
    known = '0;
    setup(atrc_pkg::TRIG_SOFTWARE, atrc_pkg::MODE_REPEAT0);
    repeat (120) @(posedge mclk);
    note();
    base <= 10'(xs());
    repeat (60) @(posedge mclk);
    note();
    start(1'b0);
    repeat (60) @(posedge mclk);
    chk_bit("busy", 1'b0, busy);
    ext_cfg.ext_irq_both_edge_sel <= 1'b1;
    fire <= 1'b1;
    repeat (2) @(posedge mclk);
    chk_bit("both edge fall", 1'b1, irqf);
    ext_cfg.irq_flag_clear <= 1'b1;
    @(posedge mclk);
    ext_cfg.irq_flag_clear <= 1'b0;
    fire <= 1'b0;
    @(posedge mclk);
    chk_bit("irq flag", 1'b0, irqf);
    @(posedge mclk);
    chk_bit("both edge rise", 1'b1, irqf);
    close_out();
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
